/* File: src/cid_decoder.sv */
// Compressed instruction decoder with halfword pairing and exception classification
`timescale 1ns/1ps
module cid_decoder
   import cid_pkg::*;
#(
   parameter bit DEBUG_PRESENT = 1'b1,
   parameter bit EXTENSION_PRESENT = 1'b0,
   parameter bit COMPAT_MODE = 1'b0
)
(
   input wire logic clk_sys,
   input wire logic reset_n,
   input wire logic [WORD_W-1:0] fetchWord,
   input wire logic fetchValid,
   input wire logic fetchUncached,
   input wire logic bigEndian,
   input wire logic kernelMode,
   input wire logic debugMode,
   input wire logic wide64Enabled,
   input wire logic restrictedCode,
   input wire logic restrictedCop,
   input wire logic copAllowed,
   input wire logic extensionCode,
   input wire logic flush,
   output logic fetchReady,
   output logic fetchHalfOnly,
   output logic opValid,
   output cid_op_type opCode,
   output logic [WORD_W-1:0] instr,
   output logic instrWide,
   output cid_exc_type exception
);
   typedef struct packed {
      cid_state_type phase;
      logic [HALF_W-1:0] firstHalf;
      logic firstIsPrefix;
      logic useUpper;
      logic fetchReady;
      logic fetchHalfOnly;
      logic opValid;
      cid_op_type opCode;
      logic [WORD_W-1:0] instr;
      logic instrWide;
      cid_exc_type exception;
   } cid_dec_type;

   cid_dec_type state;
   cid_dec_type next_state;
   logic [HALF_W-1:0] half;
   logic halfValid;
   logic [HALF_W-1:0] lead;
   logic [HALF_W-1:0] body;
   logic pairDone;
   logic prefixed;
   cid_op_type dop;
   logic resv;
   logic nonExt;
   logic [4:0] op;
   logic [2:0] sub3;
   logic [2:0] ry;
   logic [4:0] fn5;
   logic [1:0] fn2;

   // =====================================================
   // Halfword picked by endianness and position
   cid_halfword_select u_sel (
      .clk_sys(clk_sys),
      .reset_n(reset_n),
      .word(fetchWord),
      .upper(state.useUpper),
      .valid(fetchValid && !flush),
      .half(half),
      .halfValid(halfValid)
   );

   // =====================================================
   // Instruction assembly: lead halfword carries the prefix or call head
   always_comb begin
      pairDone = state.phase == CID_SECOND;
      prefixed = pairDone && state.firstIsPrefix;
      lead = pairDone ? state.firstHalf : half;
      body = (pairDone && !state.firstIsPrefix) ? state.firstHalf : half;
      op = body[OP_HI:OP_LO];
      sub3 = body[SUB3_HI:SUB3_LO];
      ry = body[RY_HI:RY_LO];
      fn5 = body[FN5_HI:FN5_LO];
      fn2 = body[FN2_HI:FN2_LO];
   end

   // =====================================================
   // Opcode and sub-field classification
   always_comb begin
      dop = CID_NONE;
      resv = 1'b0;
      nonExt = 1'b0;
      case (op)
         OP_SP_ADD: dop = CID_SP_ADD;
         OP_PC_ADD: dop = CID_PC_ADD;
         OP_BRANCH: dop = CID_BRANCH;
         OP_CALL: begin
            dop = lead[CALL_X_BIT] ? CID_CALL_SW : CID_CALL;
            nonExt = 1'b1;
         end
         OP_BRANCH_IF_ZERO: dop = CID_BRANCH_IF_ZERO;
         OP_BRANCH_IF_NONZERO: dop = CID_BRANCH_IF_NONZERO;
         OP_SHIFT: begin
            case (fn2)
               2'h0: dop = CID_SLL;
               2'h2: dop = CID_SRL;
               2'h3: dop = CID_SRA;
               default: resv = 1'b1;
            endcase
         end
         OP_RRIA: begin
            if (body[RRIA_BIT]) begin
               resv = 1'b1;
            end else begin
               dop = CID_ADD3I;
            end
         end
         OP_IMM_ADD: dop = CID_IMM_ADD;
         OP_LESS_THAN_IMM: dop = CID_LESS_THAN_IMM;
         OP_LESS_THAN_IMM_UNSIGNED: dop = CID_LESS_THAN_IMM_UNSIGNED;
         OP_I8: begin
            case (sub3)
               3'h0: dop = CID_BRANCH_T_ZERO;
               3'h1: dop = CID_BRANCH_T_NONZERO;
               3'h2: dop = CID_RA_STORE;
               3'h3: dop = CID_STACK_ADJ;
               3'h4: dop = body[FRAME_BIT] ? CID_PUSH : CID_POP;
               3'h5: begin
                  dop = CID_MOV_TO;
                  nonExt = 1'b1;
               end
               3'h7: begin
                  dop = CID_MOV_FROM;
                  nonExt = 1'b1;
               end
               default: resv = 1'b1;
            endcase
         end
         OP_LDI: dop = CID_LDI;
         OP_COMPARE_IMM: dop = CID_COMPARE_IMM;
         OP_LDB: dop = CID_LDB;
         OP_LDH: dop = CID_LDH;
         OP_LDWSP: dop = CID_LDWSP;
         OP_LDW: dop = CID_LDW;
         OP_LDBU: dop = CID_LDBU;
         OP_LDHU: dop = CID_LDHU;
         OP_LDWPC: dop = CID_LDWPC;
         OP_STB: dop = CID_STB;
         OP_STH: dop = CID_STH;
         OP_STWSP: dop = CID_STWSP;
         OP_STW: dop = CID_STW;
         OP_THREE: begin
            nonExt = 1'b1;
            case (fn2)
               2'h1: dop = CID_ADD;
               2'h3: dop = CID_SUB;
               default: resv = 1'b1;
            endcase
         end
         OP_TWO: begin
            nonExt = 1'b1;
            case (fn5)
               5'h00: begin
                  case (ry)
                     3'h0: dop = CID_JR_RX;
                     3'h1: dop = CID_JR_RA;
                     3'h2: dop = CID_JALR;
                     3'h4: dop = CID_JRC_RX;
                     3'h5: dop = CID_JRC_RA;
                     3'h6: dop = CID_JALRC;
                     default: resv = 1'b1;
                  endcase
               end
               5'h01: begin
                  if (DEBUG_PRESENT) begin
                     dop = CID_DBG_BRK;
                  end else begin
                     resv = 1'b1;
                  end
               end
               5'h02: dop = CID_SLT;
               5'h03: dop = CID_LESS_THAN_UNSIGNED;
               5'h04: dop = CID_VAR_LEFT_LOGICAL;
               5'h05: dop = CID_TRAP;
               5'h06: dop = CID_VAR_RIGHT_LOGICAL;
               5'h07: dop = CID_VAR_RIGHT_ARITH;
               5'h0a: dop = CID_CMP;
               5'h0b: dop = CID_NEGATE;
               5'h0c: dop = CID_AND;
               5'h0d: dop = CID_OR;
               5'h0e: dop = CID_XOR;
               5'h0f: dop = CID_NOT;
               5'h10: dop = CID_RD_HI;
               5'h11: begin
                  case (ry)
                     3'h0: dop = CID_ZEB;
                     3'h1: dop = CID_ZEH;
                     3'h4: dop = CID_SEB;
                     3'h5: dop = CID_SEH;
                     default: resv = 1'b1;
                  endcase
               end
               5'h12: dop = CID_RD_LO;
               5'h18: dop = CID_MULS;
               5'h19: dop = CID_MULU;
               5'h1a: dop = CID_DIVS;
               5'h1b: dop = CID_UNSIGNED_QUOTIENT;
               default: resv = 1'b1;
            endcase
         end
         default: resv = 1'b1;
      endcase
      if (op[2:0] == COL_HIGHER) begin
         resv = 1'b1;
      end
   end

   // =====================================================
   // Sequencing, fetch control and result registers
   always_comb begin
      next_state = state;
      next_state.opValid = 1'b0;
      next_state.fetchHalfOnly = fetchUncached;
      // A held word yields its halves on two edges; ask for a new word after the second
      if (fetchValid) begin
         next_state.useUpper = !state.useUpper;
         next_state.fetchReady = (state.useUpper != bigEndian);
      end
      if (flush) begin
         next_state.phase = CID_FIRST;
         next_state.useUpper = bigEndian;
         next_state.fetchReady = 1'b1;
      end else if (halfValid) begin
         if (!pairDone && (op == OP_PREFIX || op == OP_CALL)) begin
            next_state.phase = CID_SECOND;
            next_state.firstHalf = half;
            next_state.firstIsPrefix = op == OP_PREFIX;
         end else begin
            next_state.phase = CID_FIRST;
            next_state.opValid = 1'b1;
            next_state.instrWide = pairDone;
            next_state.instr = pairDone ? {state.firstHalf, half} : {{HALF_W{1'b0}}, half};
            next_state.opCode = dop;
            next_state.exception = CID_EXC_NONE;
            if (resv || (prefixed && nonExt)) begin
               next_state.exception = CID_EXC_RESERVED;
               next_state.opCode = CID_NONE;
            end else if (EXTENSION_PRESENT == 1'b0 && extensionCode) begin
               next_state.exception = CID_EXC_RESERVED;
               next_state.opCode = CID_NONE;
            end else if (COMPAT_MODE && restrictedCode && !(kernelMode || debugMode || wide64Enabled)) begin
               // Restricted code outside privileged modes traps
               next_state.exception = (restrictedCop && !copAllowed) ? CID_EXC_COP_UNUSABLE : CID_EXC_RESERVED;
               next_state.opCode = CID_NONE;
            end
         end
      end
   end

   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         state <= '{phase: CID_FIRST, useUpper: 1'b1, fetchReady: 1'b1, opCode: CID_NONE,
                    exception: CID_EXC_NONE, default: '0};
      end else begin
         state <= next_state;
      end
   end

   // =====================================================
   // Registered outputs
   assign fetchReady = state.fetchReady;
   assign fetchHalfOnly = state.fetchHalfOnly;
   assign opValid = state.opValid;
   assign opCode = state.opCode;
   assign instr = state.instr;
   assign instrWide = state.instrWide;
   assign exception = state.exception;
endmodule : cid_decoder

/* File: src/cid_pkg.sv */
// Package of opcode, function and sub-field encodings for the compressed instruction decoder
package cid_pkg;
   // =====================================================
   // Field positions inside a 16-bit instruction halfword
   localparam int OP_HI = 15;
   localparam int OP_LO = 11;
   localparam int SUB3_HI = 10;
   localparam int SUB3_LO = 8;
   localparam int RY_HI = 7;
   localparam int RY_LO = 5;
   localparam int FN5_HI = 4;
   localparam int FN5_LO = 0;
   localparam int FN2_HI = 1;
   localparam int FN2_LO = 0;
   localparam int RRIA_BIT = 4;
   localparam int FRAME_BIT = 7;
   localparam int CALL_X_BIT = 10;  // Bit 26 of the 32-bit call form, within its first halfword
   localparam int HALF_W = 16;
   localparam int WORD_W = 32;

   // =====================================================
   // Major opcodes (row bits 15..14, column bits 13..11)
   localparam logic [4:0] OP_SP_ADD = 5'h00;
   localparam logic [4:0] OP_PC_ADD = 5'h01;
   localparam logic [4:0] OP_BRANCH = 5'h02;
   localparam logic [4:0] OP_CALL = 5'h03;
   localparam logic [4:0] OP_BRANCH_IF_ZERO = 5'h04;
   localparam logic [4:0] OP_BRANCH_IF_NONZERO = 5'h05;
   localparam logic [4:0] OP_SHIFT = 5'h06;
   localparam logic [4:0] OP_RRIA = 5'h08;
   localparam logic [4:0] OP_IMM_ADD = 5'h09;
   localparam logic [4:0] OP_LESS_THAN_IMM = 5'h0a;
   localparam logic [4:0] OP_LESS_THAN_IMM_UNSIGNED = 5'h0b;
   localparam logic [4:0] OP_I8 = 5'h0c;
   localparam logic [4:0] OP_LDI = 5'h0d;
   localparam logic [4:0] OP_COMPARE_IMM = 5'h0e;
   localparam logic [4:0] OP_LDB = 5'h10;
   localparam logic [4:0] OP_LDH = 5'h11;
   localparam logic [4:0] OP_LDWSP = 5'h12;
   localparam logic [4:0] OP_LDW = 5'h13;
   localparam logic [4:0] OP_LDBU = 5'h14;
   localparam logic [4:0] OP_LDHU = 5'h15;
   localparam logic [4:0] OP_LDWPC = 5'h16;
   localparam logic [4:0] OP_STB = 5'h18;
   localparam logic [4:0] OP_STH = 5'h19;
   localparam logic [4:0] OP_STWSP = 5'h1a;
   localparam logic [4:0] OP_STW = 5'h1b;
   localparam logic [4:0] OP_THREE = 5'h1c;
   localparam logic [4:0] OP_TWO = 5'h1d;
   localparam logic [4:0] OP_PREFIX = 5'h1e;
   localparam logic [2:0] COL_HIGHER = 3'h7;

   // =====================================================
   // Decoded operations
   typedef enum logic [6:0] {
      CID_NONE, CID_SP_ADD, CID_PC_ADD, CID_BRANCH, CID_CALL, CID_CALL_SW, CID_BRANCH_IF_ZERO, CID_BRANCH_IF_NONZERO,
      CID_SLL, CID_SRL, CID_SRA, CID_ADD3I, CID_IMM_ADD, CID_LESS_THAN_IMM, CID_LESS_THAN_IMM_UNSIGNED, CID_BRANCH_T_ZERO,
      CID_BRANCH_T_NONZERO, CID_RA_STORE, CID_STACK_ADJ, CID_POP, CID_PUSH, CID_MOV_TO, CID_MOV_FROM,
      CID_LDI, CID_COMPARE_IMM, CID_LDB, CID_LDH, CID_LDWSP, CID_LDW, CID_LDBU, CID_LDHU, CID_LDWPC,
      CID_STB, CID_STH, CID_STWSP, CID_STW, CID_ADD, CID_SUB, CID_JR_RX, CID_JR_RA, CID_JALR,
      CID_JRC_RX, CID_JRC_RA, CID_JALRC, CID_DBG_BRK, CID_SLT, CID_LESS_THAN_UNSIGNED, CID_VAR_LEFT_LOGICAL, CID_TRAP,
      CID_VAR_RIGHT_LOGICAL, CID_VAR_RIGHT_ARITH, CID_CMP, CID_NEGATE, CID_AND, CID_OR, CID_XOR, CID_NOT, CID_RD_HI,
      CID_RD_LO, CID_ZEB, CID_ZEH, CID_SEB, CID_SEH, CID_MULS, CID_MULU, CID_DIVS, CID_UNSIGNED_QUOTIENT
   } cid_op_type;

   // Exception causes
   typedef enum logic [1:0] {
      CID_EXC_NONE = 2'h0, CID_EXC_RESERVED = 2'h1, CID_EXC_COP_UNUSABLE = 2'h2
   } cid_exc_type;

   // Decoder states: waiting for first halfword, or for the second of a pair
   typedef enum logic [1:0] {
      CID_FIRST = 2'b00, CID_SECOND = 2'b01
   } cid_state_type;
endpackage : cid_pkg

/* File: src/cid_halfword_select.sv */
// Halfword selector that picks one instruction halfword from a fetched word by the upper input
`timescale 1ns/1ps
module cid_halfword_select
   import cid_pkg::*;
(
   input wire logic clk_sys,
   input wire logic reset_n,
   input wire logic [WORD_W-1:0] word,
   input wire logic upper,
   input wire logic valid,
   output logic [HALF_W-1:0] half,
   output logic halfValid
);
   typedef struct packed {
      logic [HALF_W-1:0] half;
      logic halfValid;
   } cid_sel_type;

   cid_sel_type state;
   cid_sel_type next_state;

   // =====================================================
   // Pick the chosen halfword
   always_comb begin
      next_state = state;
      next_state.halfValid = valid;
      if (valid) begin
         next_state.half = upper ? word[WORD_W-1:HALF_W] : word[HALF_W-1:0];
      end
   end

   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         state <= '0;
      end else begin
         state <= next_state;
      end
   end

   assign half = state.half;
   assign halfValid = state.halfValid;
endmodule : cid_halfword_select

/* File: verification/cid_decoder_chk.sv */
// Assertion checker on the ports of the compressed instruction decoder
`timescale 1ns/1ps
module cid_decoder_chk
   import cid_pkg::*;
(
   input wire logic clk_sys,
   input wire logic reset_n,
   input wire logic fetchValid,
   input wire logic fetchUncached,
   input wire logic fetchReady,
   input wire logic fetchHalfOnly,
   input wire logic opValid,
   input wire cid_op_type opCode,
   input wire logic [WORD_W-1:0] instr,
   input wire logic instrWide,
   input wire cid_exc_type exception
);
   default clocking dc @(posedge clk_sys);
   endclocking
   default disable iff (!reset_n);
   // =====================================================
   // Result seen for a single halfword or a two-halfword form
   sequence s_one(logic [4:0] op);
      opValid && !instrWide && instr[15:11] == op;
   endsequence
   sequence s_two(logic [4:0] op);
      opValid && instrWide && instr[31:27] == op;
   endsequence
   sequence s_take;
      fetchValid && fetchReady;
   endsequence
   // =====================================================
   // Checks
   higher_col_a: assert property (s_one(instr[15:11]) ##0 instr[13:11] == COL_HIGHER |-> exception == CID_EXC_RESERVED)
      else $error("higher-level column not refused");
   shift_code_a: assert property (s_one(OP_SHIFT) ##0 instr[1:0] == 2'b01 |-> exception == CID_EXC_RESERVED)
      else $error("shift code 01 not refused");
   add_group_a: assert property (s_one(OP_RRIA) |-> opCode == (instr[4] ? CID_NONE : CID_ADD3I))
      else $error("two-register add group misdecoded");
   i8_reserved_a: assert property (s_one(OP_I8) ##0 instr[10:8] == 3'h6 |-> exception == CID_EXC_RESERVED)
      else $error("immediate group code 110 not refused");
   frame_pick_a: assert property (s_one(OP_I8) ##0 instr[10:8] == 3'h4 |-> opCode == (instr[7] ? CID_PUSH : CID_POP))
      else $error("frame group misdecoded");
   three_reg_a: assert property (s_one(OP_THREE) ##0 !instr[0] |-> exception == CID_EXC_RESERVED)
      else $error("three-register even code not refused");
   call_pick_a: assert property (s_two(OP_CALL) |-> opCode == (instr[26] ? CID_CALL_SW : CID_CALL))
      else $error("call form misdecoded");
   prefix_refuse_a: assert property (s_two(OP_PREFIX) ##0 instr[15:11] == OP_TWO |-> exception == CID_EXC_RESERVED)
      else $error("prefixed non-extensible op not refused");
   exc_no_op_a: assert property (opValid && exception != CID_EXC_NONE |-> opCode == CID_NONE)
      else $error("operation given with an exception");
   take_answer_a: assert property (s_take |-> ##[1:8] opValid)
      else $error("no result after a taken word");
   uncached_copy_a: assert property ($past(reset_n) |-> fetchHalfOnly == $past(fetchUncached))
      else $error("fetch width limit does not follow uncached");
endmodule : cid_decoder_chk

bind cid_decoder cid_decoder_chk i_chk (.clk_sys(clk_sys), .reset_n(reset_n), .fetchValid(fetchValid),
   .fetchUncached(fetchUncached), .fetchReady(fetchReady), .fetchHalfOnly(fetchHalfOnly), .opValid(opValid),
   .opCode(opCode), .instr(instr), .instrWide(instrWide), .exception(exception));

/* File: verification/cid_fetch_model.sv */
// Behavioural fetch unit that feeds aligned instruction words to the decoder
`timescale 1ns/1ps
module cid_fetch_model
   import cid_pkg::*;
(
   input wire logic clk_sys,
   input wire logic reset_n,
   input wire logic fetchReady,
   input wire logic slow,
   output logic [WORD_W-1:0] fetchWord,
   output logic fetchValid
);
   logic [WORD_W-1:0] words[$];
   logic taken;
   logic gap;
   // Hold each word for both of its halves, then move on; idle bus toggles
   always @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         fetchValid <= 1'b0;
         fetchWord <= 32'h0;
         taken <= 1'b0;
         gap <= 1'b0;
      end else if (fetchValid && fetchReady) begin
         taken <= 1'b1;
      end else if ((!fetchValid || taken) && slow && !gap) begin
         gap <= 1'b1;
         taken <= 1'b0;
         fetchValid <= 1'b0;
         fetchWord <= ~fetchWord;
      end else if (!fetchValid || taken) begin
         gap <= 1'b0;
         taken <= 1'b0;
         fetchValid <= (words.size() != 0);
         fetchWord <= (words.size() != 0) ? words.pop_front() : ~fetchWord;
      end
   end
endmodule : cid_fetch_model

/* File: verification/tb.sv */
// Self-checking testbench for the compressed instruction decoder
`timescale 1ns/1ps
module tb
   import cid_pkg::*;
;
   typedef struct packed {
      logic [WORD_W-1:0] instr;
      cid_op_type op;
      cid_exc_type exc;
      logic wide;
   } cid_exp_type;
   logic clk_sys, reset_n, fetchValid, fetchUncached, bigEndian, kernelMode, debugMode, wide64Enabled;
   logic restrictedCode, restrictedCop, copAllowed, extensionCode, flush, slow;
   logic fetchReady, fetchHalfOnly, opValid, instrWide;
   logic [WORD_W-1:0] fetchWord, instr;
   cid_op_type opCode;
   cid_exc_type exception;
   cid_exp_type expQ[$];
   cid_exp_type note;
   logic [HALF_W-1:0] halves[$];
   int nErrors = 0;
   int comparisons = 0;
   int cycles = 0;

   cid_decoder #(.COMPAT_MODE(1'b1)) i_dut (.clk_sys(clk_sys), .reset_n(reset_n), .fetchWord(fetchWord),
      .fetchValid(fetchValid), .fetchUncached(fetchUncached), .bigEndian(bigEndian), .kernelMode(kernelMode),
      .debugMode(debugMode), .wide64Enabled(wide64Enabled), .restrictedCode(restrictedCode),
      .restrictedCop(restrictedCop), .copAllowed(copAllowed), .extensionCode(extensionCode), .flush(flush),
      .fetchReady(fetchReady), .fetchHalfOnly(fetchHalfOnly), .opValid(opValid), .opCode(opCode), .instr(instr),
      .instrWide(instrWide), .exception(exception));
   cid_fetch_model i_fetch (.clk_sys(clk_sys), .reset_n(reset_n), .fetchReady(fetchReady), .slow(slow),
      .fetchWord(fetchWord), .fetchValid(fetchValid));

   // =====================================================
   // Clock and hang guard
   initial clk_sys = 1'b0;
   always #5 clk_sys = ~clk_sys;
   always @(posedge clk_sys) begin
      cycles++;
      if (cycles == 8000) begin
         nErrors++;
         $display("ERROR %0t run did not finish", $time);
         close_out();
      end
   end

   // =====================================================
   // Tasks
   task automatic check(input logic [WORD_W-1:0] seen, input logic [WORD_W-1:0] want, input string what);
      comparisons++;
      if (seen !== want) begin
         nErrors++;
         $display("ERROR %0t %s seen %h expected %h", $time, what, seen, want);
      end
   endtask : check

   task automatic add(input logic [HALF_W-1:0] h, input cid_op_type op, input cid_exc_type exc);
      halves.push_back(h);
      expQ.push_back('{instr: {16'h0, h}, op: op, exc: exc, wide: 1'b0});
   endtask : add

   task automatic add2(input logic [HALF_W-1:0] h, input logic [HALF_W-1:0] b, input cid_op_type op,
      input cid_exc_type exc);
      halves.push_back(h);
      halves.push_back(b);
      expQ.push_back('{instr: {h, b}, op: op, exc: exc, wide: 1'b1});
   endtask : add2

   task automatic fill_table;
      int k;
      cid_op_type want;
      cid_exc_type tagExc;
      // Tagged codes trap: extension-only first, then restricted outside privileged modes
      tagExc = CID_EXC_NONE;
      if (extensionCode) begin
         tagExc = CID_EXC_RESERVED;
      end else if (restrictedCode && !(kernelMode || debugMode || wide64Enabled)) begin
         tagExc = (restrictedCop && !copAllowed) ? CID_EXC_COP_UNUSABLE : CID_EXC_RESERVED;
      end
      // Random loads and stores with random operand fields
      for (int i = 0; i < 4; i++) begin
         k = $urandom_range(6);
         want = (tagExc == CID_EXC_NONE) ? cid_op_type'(CID_LDB + k) : CID_NONE;
         add({5'(OP_LDB + k), 11'($urandom)}, want, tagExc);
         k = $urandom_range(3);
         want = (tagExc == CID_EXC_NONE) ? cid_op_type'(CID_STB + k) : CID_NONE;
         add({5'(OP_STB + k), 11'($urandom)}, want, tagExc);
      end
      // Tagged passes only run the loads and stores
      if (restrictedCode || extensionCode) begin
         return;
      end
      add(16'h0000, CID_SP_ADD, CID_EXC_NONE);
      add(16'h3800, CID_NONE, CID_EXC_RESERVED);
      add(16'hb800, CID_NONE, CID_EXC_RESERVED);
      add(16'h3000, CID_SLL, CID_EXC_NONE);
      add(16'h3001, CID_NONE, CID_EXC_RESERVED);
      add(16'h3002, CID_SRL, CID_EXC_NONE);
      add(16'h3003, CID_SRA, CID_EXC_NONE);
      add(16'h4000, CID_ADD3I, CID_EXC_NONE);
      add(16'h4010, CID_NONE, CID_EXC_RESERVED);
      add(16'h5000, CID_LESS_THAN_IMM, CID_EXC_NONE);
      add(16'h6000, CID_BRANCH_T_ZERO, CID_EXC_NONE);
      add(16'h6600, CID_NONE, CID_EXC_RESERVED);
      add(16'h6700, CID_MOV_FROM, CID_EXC_NONE);
      add(16'h6400, CID_POP, CID_EXC_NONE);
      add(16'h6480, CID_PUSH, CID_EXC_NONE);
      add(16'he001, CID_ADD, CID_EXC_NONE);
      add(16'he003, CID_SUB, CID_EXC_NONE);
      add(16'he002, CID_NONE, CID_EXC_RESERVED);
      add(16'he801, CID_DBG_BRK, CID_EXC_NONE);
      add(16'he809, CID_NONE, CID_EXC_RESERVED);
      add(16'he80a, CID_CMP, CID_EXC_NONE);
      add(16'he810, CID_RD_HI, CID_EXC_NONE);
      add(16'he81b, CID_UNSIGNED_QUOTIENT, CID_EXC_NONE);
      add(16'he815, CID_NONE, CID_EXC_RESERVED);
      add(16'he800, CID_JR_RX, CID_EXC_NONE);
      add(16'he8c0, CID_JALRC, CID_EXC_NONE);
      add(16'he860, CID_NONE, CID_EXC_RESERVED);
      add(16'he891, CID_SEB, CID_EXC_NONE);
      add(16'he871, CID_NONE, CID_EXC_RESERVED);
      add(16'he851, CID_NONE, CID_EXC_RESERVED);
      add2(16'h1c00, 16'($urandom), CID_CALL_SW, CID_EXC_NONE);
      add2(16'h1800, 16'($urandom), CID_CALL, CID_EXC_NONE);
      add2(16'hf000, 16'he810, CID_NONE, CID_EXC_RESERVED);
      add2(16'hf000, 16'h4800, CID_IMM_ADD, CID_EXC_NONE);
   endtask : fill_table

   task automatic run_pass(input logic big, input logic slowFar, input logic [1:0] tags);
      int w;
      @(posedge clk_sys);
      bigEndian <= big;
      slow <= slowFar;
      flush <= 1'b1;
      {restrictedCode, extensionCode} <= tags;
      // Restricted pass runs outside every privileged mode so the trap shows
      {kernelMode, debugMode, wide64Enabled, restrictedCop, copAllowed, fetchUncached} <=
         6'($urandom) & {{3{!tags[1]}}, 3'h7};
      @(posedge clk_sys);
      flush <= 1'b0;
      fill_table();
      if (halves.size() % 2 != 0) begin
         add(16'h0000, CID_SP_ADD, CID_EXC_NONE);
      end
      // Pack halfwords into words, first halfword placed by endianness
      for (int i = 0; i < halves.size(); i += 2) begin
         i_fetch.words.push_back(big ? {halves[i], halves[i+1]} : {halves[i+1], halves[i]});
      end
      halves.delete();
      w = 0;
      while (expQ.size() != 0 && w < 2000) begin
         @(posedge clk_sys);
         w++;
      end
      check(32'(expQ.size()), 32'h0, "results missing");
      check(32'(fetchHalfOnly), 32'(fetchUncached), "fetch width");
      expQ.delete();
      $display("Test done big=%0d slow=%0d", big, slowFar);
   endtask : run_pass

   task automatic close_out;
      $display("Comparisons %0d mismatches %0d", comparisons, nErrors);
      if (nErrors == 0 && comparisons > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask : close_out

   // =====================================================
   // Scoreboard takes the oldest note at each result
   always @(negedge clk_sys) begin
      if (opValid === 1'b1) begin
         if (expQ.size() == 0) begin
            nErrors++;
            $display("ERROR %0t unexpected result", $time);
         end else begin
            note = expQ.pop_front();
            check(32'(opCode), 32'(note.op), "opcode");
            check(32'(exception), 32'(note.exc), "exception");
            check(instr, note.instr, "instr");
            check(32'(instrWide), 32'(note.wide), "width");
         end
      end
   end

   // =====================================================
   // Main sequence
   initial begin
      {reset_n, fetchUncached, bigEndian, kernelMode, debugMode, wide64Enabled} = 6'h0;
      {restrictedCode, restrictedCop, copAllowed, extensionCode, flush, slow} = 6'h0;
      repeat (10) @(posedge clk_sys);
      reset_n <= 1'b1;
      void'($urandom(32'h5dff));
      run_pass(1'b1, 1'b0, 2'b00);
      run_pass(1'b0, 1'b0, 2'b00);
      run_pass(1'b1, 1'b1, 2'b10);
      run_pass(1'b0, 1'b1, 2'b01);
      close_out();
   end
endmodule : tb
